/* src/attr_decode.v */
/*
 Combinational decode of a four-bit cache attribute into a class,
 allocation flags and write policy.
 Assumes the attribute is a registered, enable-qualified input.
*/
`timescale 1ns/1ps
`include "port_front_end_defines.vh"

module attr_decode (
	input wire [3:0] attr,
	output reg [2:0] cls,
	output reg rd_alloc,
	output reg wr_alloc,
	output reg lookup,
	output reg write_back,
	output reg bufferable
);
	// Every encoding lands in some class, listed or not
	always @* begin
		rd_alloc = 1'b0;
		wr_alloc = 1'b0;
		lookup = 1'b0;
		write_back = 1'b0;
		bufferable = attr[`ATTR_B];
		cls = `CLS_SO;
		if (!attr[`ATTR_C]) begin
			// Allocate bits ignored without cacheable
			if (attr[`ATTR_B]) begin
				cls = `CLS_DEV;
			end else begin
				cls = `CLS_SO;
			end
		end else begin
			lookup = attr[`ATTR_RA] | attr[`ATTR_WA];
			write_back = attr[`ATTR_B];
			rd_alloc = attr[`ATTR_RA];
			wr_alloc = attr[`ATTR_WA];
			if (attr[`ATTR_RA] && attr[`ATTR_WA]) begin
				cls = `CLS_RWA;
			end else if (attr[`ATTR_WA]) begin
				cls = `CLS_WA;
			end else if (attr[`ATTR_RA]) begin
				cls = `CLS_RA;
			end else begin
				cls = `CLS_NOALLOC;
			end
		end
	end
endmodule

/* src/port_front_end.v */
/*
 Port front end of a level-2 cache controller: enable-gated request
 capture on two slave ports, attribute decode, outstanding-transaction
 bookkeeping for the slave ports and the memory side, and an AHB-Lite
 slave for status and control.
 Assumes one clock; enables come from an outside divider; completion
 pulses are qualified by the same port enables as the requests.
*/
// The address map and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "port_front_end_defines.vh"

module port_front_end #(
	parameter MST_ID_W = `MST_ID_W_DEF,
	parameter SLV_ID_W = `SLV_ID_W_DEF,
	parameter TWO_MASTERS = 1
) (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [11:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output wire hreadyout,
	output wire hresp,
	input wire [1:0] s_in_en,
	input wire [1:0] s_out_en,
	input wire [1:0] m_in_en,
	input wire [1:0] m_out_en,
	input wire [1:0] s_arvalid,
	input wire [2*SLV_ID_W-1:0] s_arid,
	input wire [7:0] s_arcache,
	input wire [1:0] s_aruser,
	output reg [1:0] s_arready,
	input wire [1:0] s_awvalid,
	input wire [2*SLV_ID_W-1:0] s_awid,
	input wire [7:0] s_awcache,
	input wire [1:0] s_awuser,
	output reg [1:0] s_awready,
	input wire [1:0] s_rdone,
	input wire [1:0] s_wdone,
	output reg [1:0] m_arvalid,
	output reg [2*MST_ID_W-1:0] m_arid,
	input wire [1:0] m_arready,
	output reg [1:0] m_rd_shared,
	input wire [1:0] m_rdone,
	input wire evict_req,
	input wire store_buffer_wr_req,
	input wire store_buffer_rd_req,
	input wire evict_done,
	input wire store_buffer_wr_done,
	input wire store_buffer_rd_done,
	input wire nb_wr_done0,
	input wire nb_wr_done1,
	output wire evict_grant,
	output wire store_buffer_wr_grant,
	output wire store_buffer_rd_grant,
	output reg [1:0] cache_rd_req,
	output reg [1:0] wr_to_store_buffer,
	output reg [1:0] wr_mark_dirty,
	output reg [1:0] wr_nb_mem
);
	reg [2:0] slv_rd_r [0:1];
	reg [2:0] slv_wr_r [0:1];
	reg [4:0] mst_rd_r;
	reg [4:0] mst_wr_r;
	reg [4:0] ev_r;
	reg [4:0] stbw_r;
	reg [4:0] stbr_r;
	reg [4:0] slvr_r [0:1];
	reg [4:0] nbw_r [0:1];
	reg [31:0] ctrl_r;
	reg [31:0] err_cnt_r;
	reg [3:0] last_attr_r;
	reg [2:0] last_cls_r;
	reg ph_valid_r;
	reg ph_write_r;
	reg [11:0] ph_addr_r;
	reg [1:0] ar_take;
	reg [1:0] aw_take;
	wire [2:0] ar_cls0;
	wire [2:0] ar_cls1;
	wire [2:0] aw_cls0;
	wire [2:0] aw_cls1;
	wire [1:0] ar_look;
	wire [1:0] aw_wb;
	wire [1:0] aw_look;
	wire [4:0] mst_all;
	wire mst_port1;
	wire ahb_go;
	integer i;

	// Room left under a limit; used for the memory-side counters
	function room;
		input [4:0] cnt;
		input [4:0] lim;
		begin
			room = (cnt < lim);
		end
	endfunction

	// Attribute decoders, one per slave channel
	attr_decode u_ar0 (.attr(s_arcache[3:0]), .cls(ar_cls0), .rd_alloc(), .wr_alloc(),
		.lookup(ar_look[0]), .write_back(), .bufferable());
	attr_decode u_ar1 (.attr(s_arcache[7:4]), .cls(ar_cls1), .rd_alloc(), .wr_alloc(),
		.lookup(ar_look[1]), .write_back(), .bufferable());
	attr_decode u_aw0 (.attr(s_awcache[3:0]), .cls(aw_cls0), .rd_alloc(), .wr_alloc(),
		.lookup(aw_look[0]), .write_back(aw_wb[0]), .bufferable());
	attr_decode u_aw1 (.attr(s_awcache[7:4]), .cls(aw_cls1), .rd_alloc(), .wr_alloc(),
		.lookup(aw_look[1]), .write_back(aw_wb[1]), .bufferable());

	// Whole-controller totals; port split kept only in slvr_r and nbw_r
	assign mst_all = mst_rd_r + mst_wr_r;
	assign mst_port1 = (TWO_MASTERS != 0);

	// Grants for internal requesters against shared limits
	assign evict_grant = evict_req && room(ev_r, `MST_EVICT_MAX) && room(mst_wr_r, `MST_WR_MAX)
		&& room(mst_all, `MST_ALL_MAX);
	assign store_buffer_wr_grant = store_buffer_wr_req && !evict_grant && room(stbw_r, `MST_STORE_WR_MAX)
		&& room(mst_wr_r, `MST_WR_MAX) && room(mst_all, `MST_ALL_MAX);
	assign store_buffer_rd_grant = store_buffer_rd_req && room(stbr_r, `MST_STORE_RD_MAX)
		&& room(mst_rd_r, `MST_RD_MAX) && room(mst_all, `MST_ALL_MAX);

	// Acceptance per slave port; sampled only on input enable
	always @* begin
		for (i = 0; i < 2; i = i + 1) begin
			ar_take[i] = s_in_en[i] && s_arvalid[i] && s_arready[i];
			aw_take[i] = s_in_en[i] && s_awvalid[i] && s_awready[i];
		end
	end

	// Slave-side outstanding counters and ready outputs
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (i = 0; i < 2; i = i + 1) begin
				slv_rd_r[i] <= 3'h0;
				slv_wr_r[i] <= 3'h0;
			end
			s_arready <= 2'h0;
			s_awready <= 2'h0;
		end else begin
			for (i = 0; i < 2; i = i + 1) begin
				slv_rd_r[i] <= slv_rd_r[i] + {2'h0, ar_take[i]} - {2'h0, s_in_en[i] & s_rdone[i]};
				slv_wr_r[i] <= slv_wr_r[i] + {2'h0, aw_take[i]} - {2'h0, s_in_en[i] & s_wdone[i]};
				if (s_out_en[i]) begin
					// Ready is conservative: assumes no completion this cycle
					s_arready[i] <= !ctrl_r[0] && (slv_rd_r[i] + {2'h0, ar_take[i]} < `SLV_RD_MAX)
						&& (slv_rd_r[i] + slv_wr_r[i] + {2'h0, ar_take[i]} + {2'h0, aw_take[i]}
						< `SLV_ALL_MAX);
					s_awready[i] <= !ctrl_r[0] && (slv_wr_r[i] + {2'h0, aw_take[i]} < `SLV_WR_MAX)
						&& (slv_rd_r[i] + slv_wr_r[i] + {2'h0, ar_take[i]} + {2'h0, aw_take[i]}
						< `SLV_ALL_MAX)
						&& room(nbw_r[i] + {4'h0, aw_take[i]}, `MST_NB_WR_MAX);
				end
			end
		end
	end

	// Routing of accepted requests and memory-side read issue
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			m_arvalid <= 2'h0;
			m_arid <= {2*MST_ID_W{1'b0}};
			m_rd_shared <= 2'h0;
			cache_rd_req <= 2'h0;
			wr_to_store_buffer <= 2'h0;
			wr_mark_dirty <= 2'h0;
			wr_nb_mem <= 2'h0;
			last_attr_r <= 4'h0;
			last_cls_r <= `CLS_SO;
		end else begin
			cache_rd_req <= ar_take & ar_look;
			wr_to_store_buffer <= aw_take & {aw_cls1 != `CLS_SO && aw_cls1 != `CLS_DEV,
				aw_cls0 != `CLS_SO && aw_cls0 != `CLS_DEV};
			wr_nb_mem <= aw_take & {aw_cls1 == `CLS_SO || aw_cls1 == `CLS_DEV,
				aw_cls0 == `CLS_SO || aw_cls0 == `CLS_DEV};
			wr_mark_dirty <= aw_take & aw_look & aw_wb;
			if (ar_take[0]) begin
				last_attr_r <= s_arcache[3:0];
				last_cls_r <= ar_cls0;
			end
			// Port 0 always; port 1 only when present
			for (i = 0; i < 2; i = i + 1) begin
				if (m_out_en[i] && (i == 0 || mst_port1)) begin
					if (m_arvalid[i] && m_arready[i] && m_in_en[i]) begin
						m_arvalid[i] <= 1'b0;
					end
				end
			end
			// Bypass reads go out on port 0 for slave 0, and on port 1 for slave 1 only when TWO_MASTERS is set (else port 0)
			if (m_out_en[0] && !m_arvalid[0] && ar_take[0] && !ar_look[0]) begin
				m_arvalid[0] <= 1'b1;
				m_arid[MST_ID_W-1:0] <= {{(MST_ID_W-SLV_ID_W){1'b0}}, s_arid[SLV_ID_W-1:0]};
				m_rd_shared[0] <= s_aruser[0];
			end
			if (m_out_en[mst_port1] && !m_arvalid[mst_port1] && ar_take[1] && !ar_look[1]) begin
				m_arvalid[mst_port1] <= 1'b1;
				m_arid[MST_ID_W*(mst_port1+1)-1 -: MST_ID_W] <=
					{{(MST_ID_W-SLV_ID_W){1'b0}}, s_arid[2*SLV_ID_W-1:SLV_ID_W]};
				m_rd_shared[mst_port1] <= s_aruser[1];
			end
		end
	end

	// Memory-side outstanding bookkeeping, whole controller plus per port in slvr_r and nbw_r
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mst_rd_r <= 5'h0;
			mst_wr_r <= 5'h0;
			ev_r <= 5'h0;
			stbw_r <= 5'h0;
			stbr_r <= 5'h0;
			for (i = 0; i < 2; i = i + 1) begin
				slvr_r[i] <= 5'h0;
				nbw_r[i] <= 5'h0;
			end
		end else begin
			ev_r <= ev_r + {4'h0, evict_grant} - {4'h0, evict_done};
			stbw_r <= stbw_r + {4'h0, store_buffer_wr_grant} - {4'h0, store_buffer_wr_done};
			stbr_r <= stbr_r + {4'h0, store_buffer_rd_grant} - {4'h0, store_buffer_rd_done};
			nbw_r[0] <= nbw_r[0] + {4'h0, wr_nb_mem[0]} - {4'h0, nb_wr_done0};
			nbw_r[1] <= nbw_r[1] + {4'h0, wr_nb_mem[1]} - {4'h0, nb_wr_done1};
			for (i = 0; i < 2; i = i + 1) begin
				slvr_r[i] <= slvr_r[i] + {4'h0, ar_take[i] & ~ar_look[i]} - {4'h0, m_in_en[i] & m_rdone[i]};
			end
			mst_wr_r <= mst_wr_r + {4'h0, evict_grant} + {4'h0, store_buffer_wr_grant} + {4'h0, wr_nb_mem[0]}
				+ {4'h0, wr_nb_mem[1]} - {4'h0, evict_done} - {4'h0, store_buffer_wr_done}
				- {4'h0, nb_wr_done0} - {4'h0, nb_wr_done1};
			mst_rd_r <= mst_rd_r + {4'h0, store_buffer_rd_grant} + {4'h0, ar_take[0] & ~ar_look[0]}
				+ {4'h0, ar_take[1] & ~ar_look[1]} - {4'h0, store_buffer_rd_done}
				- {4'h0, m_in_en[0] & m_rdone[0]} - {4'h0, m_in_en[1] & m_rdone[1]};
		end
	end

	// AHB-Lite slave: zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign ahb_go = hsel && hready && htrans[1];

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_valid_r <= 1'b0;
			ph_write_r <= 1'b0;
			ph_addr_r <= 12'h000;
			ctrl_r <= `CTRL_RESET;
			err_cnt_r <= 32'h0000_0000;
		end else begin
			if (hready) begin
				ph_valid_r <= ahb_go;
				ph_write_r <= hwrite;
				ph_addr_r <= haddr;
			end
			// Only the control word is writable
			if (ph_valid_r && ph_write_r && ph_addr_r == `REG_CTRL) begin
				ctrl_r <= {31'h0, hwdata[0]};
			end
			// Counts breaches of the slave write and memory read and write limits; should stay zero
			if (slv_wr_r[0] > `SLV_WR_MAX || slv_wr_r[1] > `SLV_WR_MAX || mst_wr_r > `MST_WR_MAX
				|| mst_rd_r > `MST_RD_MAX) begin
				err_cnt_r <= err_cnt_r + 32'h0000_0001;
			end
		end
	end

	// Read mux; unmapped offsets read zero
	always @* begin
		if (ph_addr_r == `REG_STATUS) begin
			hrdata = err_cnt_r;
		end else if (ph_addr_r == `REG_MST_CNT) begin
			hrdata = {11'h0, mst_all, 3'h0, mst_wr_r, 3'h0, mst_rd_r};
		end else if (ph_addr_r == `REG_SLV0_CNT) begin
			hrdata = {21'h0, slvr_r[0][2:0], 1'b0, slv_wr_r[0], 1'b0, slv_rd_r[0]};
		end else if (ph_addr_r == `REG_SLV1_CNT) begin
			hrdata = {21'h0, slvr_r[1][2:0], 1'b0, slv_wr_r[1], 1'b0, slv_rd_r[1]};
		end else if (ph_addr_r == `REG_CTRL) begin
			hrdata = ctrl_r;
		end else if (ph_addr_r == `REG_DECODE) begin
			hrdata = {25'h0, last_cls_r, last_attr_r};
		end else begin
			hrdata = 32'h0000_0000;
		end
	end
endmodule

/* src/port_front_end_defines.vh */
/*
 Constants for the cache port front end: outstanding limits,
 cache attribute bit positions, routing classes and register map.
 Assumes inclusion by bare name from design files.
*/
`ifndef PORT_FRONT_END_DEFINES_VH
`define PORT_FRONT_END_DEFINES_VH

// Memory-side issuing limits, whole controller; MST_NB_WR_MAX applies per port
`define MST_WR_MAX 5'h08
`define MST_RD_MAX 5'h0b
`define MST_ALL_MAX 5'h19
`define MST_EVICT_MAX 5'h03
`define MST_STORE_WR_MAX 5'h03
`define MST_STORE_RD_MAX 5'h03
`define MST_NB_WR_MAX 5'h01
`define MST_SLV_RD_MAX 5'h04
// Per slave port acceptance limits
`define SLV_WR_MAX 3'h1
`define SLV_RD_MAX 3'h4
`define SLV_ALL_MAX 3'h5
// Default ID widths
`define MST_ID_W_DEF 8
`define SLV_ID_W_DEF 6
// Cache attribute bit positions
`define ATTR_WA 3
`define ATTR_RA 2
`define ATTR_C 1
`define ATTR_B 0
`define SHARED_BIT 0
// Routing class codes
`define CLS_SO 3'h0
`define CLS_DEV 3'h1
`define CLS_NOALLOC 3'h2
`define CLS_RA 3'h3
`define CLS_WA 3'h4
`define CLS_RWA 3'h5
// AHB register map (byte addresses), control reset value and NONSEQ code
`define REG_STATUS 12'h000
`define REG_MST_CNT 12'h004
`define REG_SLV0_CNT 12'h008
`define REG_SLV1_CNT 12'h00c
`define REG_CTRL 12'h010
`define REG_DECODE 12'h014
`define CTRL_RESET 32'h0000_0000
`define HTRANS_NONSEQ 2'h2

`endif

/* verif/mem_side_model.sv */
/*
 Memory-side partner: accepts and completes bypass reads on both master ports.
 Assumes the enables mark the edges of the slower memory bus clock.
*/
`timescale 1ns/1ps
module mem_side_model (
	input wire hclk,
	input wire hresetn,
	input wire [1:0] m_in_en,
	input wire slow,
	input wire [1:0] m_arvalid,
	output reg [1:0] m_arready,
	output reg [1:0] m_rdone
);
	reg [1:0] lag_r [0:1];
	integer i;
	// Moves only on bus edges; slow mode holds ready back three bus cycles
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			m_arready <= 2'h0;
			m_rdone <= 2'h0;
			lag_r[0] <= 2'h0;
			lag_r[1] <= 2'h0;
		end else begin
			for (i = 0; i < 2; i = i + 1) begin
				if (m_in_en[i]) begin
					m_rdone[i] <= m_arvalid[i] & m_arready[i];
					m_arready[i] <= m_arvalid[i] & !m_arready[i] & (!slow | lag_r[i] == 2'h3);
					lag_r[i] <= (m_arvalid[i] & !m_arready[i]) ? lag_r[i] + 2'h1 : 2'h0;
				end
			end
		end
	end
endmodule

/* verif/port_front_end_bench.sv */
/*
 Bench for the port front end: register access, attribute decode, limits.
 Assumes a single AHB-Lite slave and one enable waveform for all ports.
*/
`timescale 1ns/1ps
`include "port_front_end_defines.vh"
module port_front_end_bench;
	reg hclk, hresetn, hsel, hwrite, slow, sh, ev, sw, sr, evd, swd, srd, nbd;
	reg [7:0] aid;
	reg [11:0] haddr, s_arid, s_awid;
	reg [1:0] htrans, s_arvalid, s_aruser, s_awvalid, s_rdone, s_wdone, en;
	reg [31:0] hwdata, rd;
	reg [7:0] s_arcache, s_awcache;
	wire [31:0] hrdata;
	wire hreadyout, evict_grant, store_buffer_wr_grant, store_buffer_rd_grant;
	wire [15:0] m_arid;
	wire [1:0] s_arready, s_awready, m_arvalid, m_arready, m_rd_shared, m_rdone;
	integer bad_count, checked, i, n, ratio, phase, ge, gs, gr;
	port_front_end dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(), .s_in_en(en), .s_out_en(en), .m_in_en(en), .m_out_en(en), .s_arvalid(s_arvalid), .s_arid(s_arid),
		.s_arcache(s_arcache), .s_aruser(s_aruser), .s_arready(s_arready), .s_awvalid(s_awvalid), .s_awid(s_awid),
		.s_awcache(s_awcache), .s_awuser(2'h0), .s_awready(s_awready), .s_rdone(s_rdone), .s_wdone(s_wdone),
		.m_arvalid(m_arvalid), .m_arid(m_arid), .m_arready(m_arready), .m_rd_shared(m_rd_shared), .m_rdone(m_rdone),
		.evict_req(ev), .store_buffer_wr_req(sw), .store_buffer_rd_req(sr), .evict_done(evd),
		.store_buffer_wr_done(swd), .store_buffer_rd_done(srd), .nb_wr_done0(nbd), .nb_wr_done1(1'b0),
		.evict_grant(evict_grant), .store_buffer_wr_grant(store_buffer_wr_grant),
		.store_buffer_rd_grant(store_buffer_rd_grant), .cache_rd_req(), .wr_to_store_buffer(), .wr_mark_dirty(),
		.wr_nb_mem());
	mem_side_model mem (.hclk(hclk), .hresetn(hresetn), .m_in_en(en), .slow(slow), .m_arvalid(m_arvalid),
		.m_arready(m_arready), .m_rdone(m_rdone));
	initial begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end
	// One waveform for input and output enables, as an integer ratio needs
	always @(posedge hclk) begin
		phase <= (phase + 1) % ratio;
		en <= ((phase + 1) % ratio == 0) ? 2'h3 : 2'h0;
	end
	// Shared flag as shown with each bypass read
	always @(negedge hclk) begin
		if (m_arvalid[0] === 1'b1) begin
			sh = m_rd_shared[0];
			aid = m_arid[7:0];
		end
	end
	task close_out;
		begin
			if (bad_count == 0 && checked > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask
	task check(input [31:0] seen, input [31:0] want);
		begin
			checked = checked + 1;
			if (seen !== want) begin
				bad_count = bad_count + 1;
				$display("unexpected at %0t: saw %h wanted %h", $time, seen, want);
			end
		end
	endtask
	task tmo;
		begin
			bad_count = bad_count + 1;
			$display("unexpected at %0t: wait ran out", $time);
			close_out;
		end
	endtask
	task hwait;
		begin
			n = 0;
			@(posedge hclk);
			while (hreadyout !== 1'b1 && n < 50) begin
				n = n + 1;
				@(posedge hclk);
			end
			if (n >= 50) tmo;
		end
	endtask
	// Single word transfer; address held until ready, data taken at the closing edge
	task ahb(input w, input [11:0] a, input [31:0] d);
		begin
			hsel <= 1'b1;
			hwrite <= w;
			haddr <= a;
			htrans <= `HTRANS_NONSEQ;
			hwait;
			htrans <= 2'h0;
			hsel <= 1'b0;
			hwdata <= d;
			hwait;
			rd = hrdata;
		end
	endtask
	// Kind 0 read ready, 1 write ready, 2 any enabled edge
	task wait_en(input [1:0] kind);
		begin
			n = 0;
			@(negedge hclk);
			while ((en[0] & (kind[1] | (kind[0] ? s_awready[0] : s_arready[0]))) !== 1'b1 && n < 80) begin
				n = n + 1;
				@(negedge hclk);
			end
			if (n >= 80) tmo;
			@(posedge hclk);
		end
	endtask
	// No burst field is driven, so no request is ever a fixed burst
	task take(input wr, input [3:0] attr);
		begin
			s_arcache[3:0] <= attr;
			s_awcache[3:0] <= attr;
			s_arid[5:0] <= s_arid[5:0] + 6'h1;
			s_awid[5:0] <= s_arid[5:0];
			s_arvalid[0] <= !wr;
			s_awvalid[0] <= wr;
			wait_en({1'b0, wr});
			s_arvalid[0] <= 1'b0;
			s_awvalid[0] <= 1'b0;
			@(posedge hclk);
		end
	endtask
	// Non-cacheable writes also retire at memory; done is ungated, so writes stay at full rate
	task pulse(input wr);
		begin
			s_rdone[0] <= !wr;
			s_wdone[0] <= wr;
			nbd <= wr & !s_awcache[1];
			wait_en(2'h2);
			s_rdone[0] <= 1'b0;
			s_wdone[0] <= 1'b0;
			nbd <= 1'b0;
			@(posedge hclk);
		end
	endtask
	function [2:0] cls_of(input [3:0] a);
		cls_of = !a[1] ? (a[0] ? `CLS_DEV : `CLS_SO) :
			(a[3] ? (a[2] ? `CLS_RWA : `CLS_WA) : (a[2] ? `CLS_RA : `CLS_NOALLOC));
	endfunction
	initial begin
		{hresetn, hsel, hwrite, haddr, htrans, hwdata, s_arvalid, s_aruser, s_awvalid, s_rdone, s_wdone} = 0;
		{s_arid, s_awid, s_arcache, s_awcache, ev, sw, sr, evd, swd, srd, nbd, slow, phase, ge, gs, gr} = 0;
		{bad_count, checked} = 0;
		ratio = 1;
		en = 2'h3;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		ahb(0, `REG_CTRL, 0);
		check(rd, `CTRL_RESET);
		ahb(1, `REG_CTRL, 32'h1);
		ahb(0, `REG_CTRL, 0);
		check(rd, 32'h1);
		ahb(1, 12'h020, 32'hffff_ffff);
		ahb(0, 12'h020, 0);
		check(rd, 32'h0);
		ahb(1, `REG_CTRL, 0);
		// Every attribute code through a read and a write
		for (i = 0; i < 16; i = i + 1) begin
			sh = 1'bx;
			s_aruser[0] <= i[0];
			take(0, i[3:0]);
			ahb(0, `REG_DECODE, 0);
			check(rd, {25'h0, cls_of(i[3:0]), i[3:0]});
			pulse(0);
			repeat (12) @(posedge hclk);
			if (!i[1] || i[3:2] == 2'h0) begin
				check(sh, i[0]);
				check(aid, {2'h0, s_arid[5:0]});
			end
			take(1, i[3:0]);
			pulse(1);
		end
		// Fifth read and second write are held off until one retires
		for (i = 0; i < 4; i = i + 1) take(0, 4'hf);
		s_arvalid[0] <= 1'b1;
		repeat (20) @(negedge hclk);
		check(s_arready[0], 0);
		@(posedge hclk);
		ahb(0, `REG_SLV0_CNT, 0);
		check(rd, 32'h4);
		pulse(0);
		wait_en(2'h0);
		s_arvalid[0] <= 1'b0;
		for (i = 0; i < 4; i = i + 1) pulse(0);
		take(1, 4'h7);
		s_awvalid[0] <= 1'b1;
		repeat (20) @(negedge hclk);
		check(s_awready[0], 0);
		@(posedge hclk);
		ahb(0, `REG_SLV0_CNT, 0);
		check(rd, 32'h10);
		pulse(1);
		wait_en(2'h1);
		s_awvalid[0] <= 1'b0;
		pulse(1);
		// Buffer requests held until every class meets its ceiling
		{ev, sw, sr} <= 3'h7;
		repeat (12) begin
			@(negedge hclk);
			ge = ge + evict_grant;
			gs = gs + store_buffer_wr_grant;
			gr = gr + store_buffer_rd_grant;
		end
		@(posedge hclk);
		{ev, sw, sr} <= 3'h0;
		check(ge, 3);
		check(gs, 3);
		check(gr, 3);
		ahb(0, `REG_MST_CNT, 0);
		check(rd, 32'h0009_0603);
		repeat (3) begin
			{evd, swd, srd} <= 3'h7;
			@(posedge hclk);
			{evd, swd, srd} <= 3'h0;
			@(posedge hclk);
		end
		// Slow bus at one third rate with a lagging memory
		ratio = 3;
		slow = 1'b1;
		sh = 1'bx;
		s_aruser[0] <= 1'b0;
		take(0, 4'h1);
		pulse(0);
		repeat (60) @(negedge hclk);
		check(sh, 1'b0);
		check(aid, {2'h0, s_arid[5:0]});
		close_out;
	end
endmodule

/* verif/port_front_end_properties.sv */
/*
 Checker for the port front end: port limits, enable gating, read routing.
 Assumes a bind to port_front_end and one clock with active-low reset.
*/
`timescale 1ns/1ps
module port_front_end_properties (
	input wire hclk,
	input wire hresetn,
	input wire [1:0] s_in_en,
	input wire [1:0] s_out_en,
	input wire [1:0] m_out_en,
	input wire [1:0] s_arvalid,
	input wire [7:0] s_arcache,
	input wire [1:0] s_arready,
	input wire [1:0] s_awvalid,
	input wire [7:0] s_awcache,
	input wire [1:0] s_awready,
	input wire [1:0] s_rdone,
	input wire [1:0] s_wdone,
	input wire [1:0] m_arvalid,
	input wire evict_grant,
	input wire evict_done,
	input wire [1:0] cache_rd_req,
	input wire [1:0] wr_mark_dirty
);
	reg [3:0] rd_r, wr_r, ev_r;
	wire rd_take = s_in_en[0] & s_arvalid[0] & s_arready[0];
	wire wr_take = s_in_en[0] & s_awvalid[0] & s_awready[0];
	// Shadow counts, so limits are judged from the handshakes alone
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_r <= 4'h0;
			wr_r <= 4'h0;
			ev_r <= 4'h0;
		end else begin
			rd_r <= rd_r + {3'h0, rd_take} - {3'h0, s_in_en[0] & s_rdone[0]};
			wr_r <= wr_r + {3'h0, wr_take} - {3'h0, s_in_en[0] & s_wdone[0]};
			ev_r <= ev_r + {3'h0, evict_grant} - {3'h0, evict_done};
		end
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	read_cap_a: assert property (rd_r <= 4'h4) else $error("port read count above four");
	write_cap_a: assert property (wr_r <= 4'h1) else $error("port write count above one");
	ready_gate_a: assert property ($changed(s_arready[0]) |-> $past(s_out_en[0]))
		else $error("read ready moved without output enable");
	issue_gate_a: assert property ($changed(m_arvalid[0]) |-> $past(m_out_en[0]))
		else $error("memory read valid moved without output enable");
	take_gate_a: assert property (cache_rd_req[0] |-> $past(rd_take))
		else $error("cache read without an enabled handshake");
	read_route_a: assert property (rd_take |=>
		cache_rd_req[0] == ($past(s_arcache[1]) && $past(s_arcache[3]) | $past(s_arcache[2])))
		else $error("read routed against its attribute");
	dirty_mark_a: assert property (wr_mark_dirty[0] |-> $past(wr_take) && $past(s_awcache[0])
		&& $past(s_awcache[1])) else $error("dirty mark on a write that is not write-back");
	evict_cap_a: assert property (ev_r <= 4'h3) else $error("more than three evictions granted");
endmodule

bind port_front_end port_front_end_properties chk (.hclk(hclk), .hresetn(hresetn), .s_in_en(s_in_en),
	.s_out_en(s_out_en), .m_out_en(m_out_en), .s_arvalid(s_arvalid), .s_arcache(s_arcache), .s_arready(s_arready),
	.s_awvalid(s_awvalid), .s_awcache(s_awcache), .s_awready(s_awready), .s_rdone(s_rdone), .s_wdone(s_wdone),
	.m_arvalid(m_arvalid), .evict_grant(evict_grant), .evict_done(evict_done), .cache_rd_req(cache_rd_req),
	.wr_mark_dirty(wr_mark_dirty));
